// ---- rbw_defs.vh ----
`ifndef RBW_DEFS_VH
`define RBW_DEFS_VH
// Register byte offsets.
`define RBW_REG_RELAY 12'h000
`define RBW_REG_VALVE 12'h004
`define RBW_REG_LAMP 12'h008
`define RBW_REG_STATUS 12'h00C
`define RBW_REG_INT_STAT 12'h010
`define RBW_REG_INT_MASK 12'h014
`define RBW_REG_STALL_CNT 12'h018
// Relay register field positions.
`define RBW_RLY_CHAMBER 0
`define RBW_RLY_CONVERTER 1
`define RBW_RLY_PERM 2
`define RBW_RLY_LAMP_SRC 3
`define RBW_RLY_PUMP 4
`define RBW_RLY_HEARTBEAT 5
`define RBW_RELAY_W 6
// Valve register field positions.
`define RBW_VLV_SAMPLE_CAL 0
`define RBW_VLV_ZERO_SPAN 1
`define RBW_VLV_MEASURE_SEL 2
`define RBW_VLV_SHUTTER 3
// Status and interrupt bits.
`define RBW_ST_STALL 0
`define RBW_ST_BEAT 1
`define RBW_EV_STALL 0
`define RBW_EV_BEAT 1
`define RBW_EV_W 2
// Reset values.
`define RBW_RELAY_RST 6'h00
`define RBW_VALVE_RST 8'h00
`define RBW_LAMP_RST 13'h0000
`define RBW_MASK_RST 2'h0
// Timing.
`define RBW_CLK_HZ 100000000
`define RBW_STALL_SEC 30
`define RBW_STALL_CYCLES 32'hB2D05E00
`define RBW_TMR_W 32
`endif

// ---- rbw_valve_driver.v ----
`timescale 1ns/10ps
`default_nettype none
// One valve driver unit with CHANNELS outputs, four by default; a forced shutdown overrides all commands.
module rbw_valve_driver #(
  parameter CHANNELS = 4
) (
  input wire core_clk, // System clock.
  input wire rst_sync_n, // Synchronised reset, active low.
  input wire clk_en, // Clock enable.
  input wire [CHANNELS-1:0] cmd, // Commanded valve states.
  input wire force_off, // Watchdog shutdown.
  output reg [CHANNELS-1:0] drive // Valve drive outputs.
);
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drive <= {CHANNELS{1'b0}};
    end else if (clk_en) begin
      drive <= force_off ? {CHANNELS{1'b0}} : cmd;
    end
  end
endmodule // rbw_valve_driver
`default_nettype wire

// ---- rbw_relay_board.v ----
`timescale 1ns/10ps
`default_nettype none
`include "rbw_defs.vh"
module rbw_relay_board #(
  parameter [`RBW_TMR_W-1:0] STALL_CYCLES = `RBW_STALL_CYCLES
) (
  input wire core_clk, // System clock, 100 MHz.
  input wire rst_n, // Asynchronous reset, active low.
  input wire clk_en, // Clock enable; state freezes while low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB write.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error for unmapped address.
  output reg chamber_heater, // Sample chamber heater relay.
  output reg converter_heater, // Converter heater relay.
  output reg perm_tube_heater, // Permeation tube heater relay.
  output reg lamp_source, // Lamp source relay.
  output reg sample_pump, // Sample pump relay.
  output reg [7:0] valve_drive, // Eight valve drive outputs.
  output reg [12:0] status_lamps, // Thirteen status lamps, index 0 is position 1.
  output reg heartbeat_lamp, // Watchdog heartbeat lamp.
  output reg chamber_heater_lamp, // Chamber heater lamp.
  output reg converter_heater_lamp, // Converter heater lamp.
  output reg perm_tube_heater_lamp, // Permeation tube heater lamp.
  output reg sample_cal_valve_lamp, // Sample/cal valve lamp.
  output reg zero_span_valve_lamp, // Zero/span valve lamp.
  output reg stall, // Watchdog shutdown active.
  output reg irq // Interrupt, active high level.
);
  reg rst_meta;
  reg rst_sync_n;
  reg [`RBW_RELAY_W-1:0] relay_cmd;
  reg [7:0] valve_cmd;
  reg [12:0] lamp_cmd;
  reg [`RBW_EV_W-1:0] int_stat;
  reg [`RBW_EV_W-1:0] int_mask;
  reg [`RBW_TMR_W-1:0] stall_cnt;
  reg beat_prev;
  reg stalled;
  wire [7:0] valve_out;
  wire beat;
  wire beat_change;
  wire stall_hit;
  wire wr_en;
  wire rd_en;
  wire [`RBW_EV_W-1:0] ev;
  reg [31:0] next_prdata;
  reg next_err;

  // Reset release through two flip-flops.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // A write lands at the edge where the master samples pready high, never earlier.
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  assign beat = relay_cmd[`RBW_RLY_HEARTBEAT];
  assign beat_change = beat != beat_prev;
  assign stall_hit = !stalled && !beat_change && (stall_cnt >= STALL_CYCLES - 1'b1);
  assign ev = {beat_change, stall_hit};

  // The host writes the whole command word; bits 0 to 4 each drive one relay independently, bit 5 is the heartbeat.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      relay_cmd <= `RBW_RELAY_RST;
      valve_cmd <= `RBW_VALVE_RST;
      lamp_cmd <= `RBW_LAMP_RST;
      int_mask <= `RBW_MASK_RST;
    end else if (clk_en && wr_en) begin
      case (paddr)
        `RBW_REG_RELAY: relay_cmd <= pwdata[`RBW_RELAY_W-1:0];
        `RBW_REG_VALVE: valve_cmd <= pwdata[7:0];
        `RBW_REG_LAMP: lamp_cmd <= pwdata[12:0];
        `RBW_REG_INT_MASK: int_mask <= pwdata[`RBW_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Stall timer; it only ends on a host heartbeat change, so a stalled board stays safe.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stall_cnt <= {`RBW_TMR_W{1'b0}};
      beat_prev <= 1'b0;
      stalled <= 1'b0;
    end else if (clk_en) begin
      beat_prev <= beat;
      if (beat_change) begin
        stall_cnt <= {`RBW_TMR_W{1'b0}};
        stalled <= 1'b0;
      end else if (stall_hit) begin
        stalled <= 1'b1;
      end else if (!stalled) begin
        stall_cnt <= stall_cnt + 1'b1;
      end
    end
  end

  // Sticky events; a new event wins over a write-one-to-clear in the same cycle.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_stat <= {`RBW_EV_W{1'b0}};
    end else if (clk_en) begin
      if (wr_en && paddr == `RBW_REG_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[`RBW_EV_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
    end
  end

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_vdrv
      rbw_valve_driver #(
        .CHANNELS(4)
      ) u_vdrv (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .clk_en(clk_en),
        .cmd(valve_cmd[u*4 +: 4]),
        .force_off(stalled || stall_hit),
        .drive(valve_out[u*4 +: 4])
      );
    end
  endgenerate

  // Outputs; valve drives already pass one register inside the driver units.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chamber_heater <= 1'b0;
      converter_heater <= 1'b0;
      perm_tube_heater <= 1'b0;
      lamp_source <= 1'b0;
      sample_pump <= 1'b0;
      valve_drive <= 8'h00;
      status_lamps <= 13'h0000;
      heartbeat_lamp <= 1'b0;
      chamber_heater_lamp <= 1'b0;
      converter_heater_lamp <= 1'b0;
      perm_tube_heater_lamp <= 1'b0;
      sample_cal_valve_lamp <= 1'b0;
      zero_span_valve_lamp <= 1'b0;
      stall <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      chamber_heater <= relay_cmd[`RBW_RLY_CHAMBER] && !(stalled || stall_hit);
      converter_heater <= relay_cmd[`RBW_RLY_CONVERTER] && !(stalled || stall_hit);
      perm_tube_heater <= relay_cmd[`RBW_RLY_PERM] && !(stalled || stall_hit);
      lamp_source <= relay_cmd[`RBW_RLY_LAMP_SRC] && !(stalled || stall_hit);
      sample_pump <= relay_cmd[`RBW_RLY_PUMP];
      valve_drive <= valve_out;
      heartbeat_lamp <= beat;
      chamber_heater_lamp <= relay_cmd[`RBW_RLY_CHAMBER] && !(stalled || stall_hit);
      converter_heater_lamp <= relay_cmd[`RBW_RLY_CONVERTER] && !(stalled || stall_hit);
      perm_tube_heater_lamp <= relay_cmd[`RBW_RLY_PERM] && !(stalled || stall_hit);
      sample_cal_valve_lamp <= valve_out[`RBW_VLV_SAMPLE_CAL];
      zero_span_valve_lamp <= valve_out[`RBW_VLV_ZERO_SPAN];
      // Assigned positions follow the board state; unassigned ones follow software.
      status_lamps <= {lamp_cmd[12:11], valve_out[`RBW_VLV_SHUTTER], lamp_cmd[9],
        valve_out[`RBW_VLV_MEASURE_SEL], valve_out[`RBW_VLV_ZERO_SPAN],
        valve_out[`RBW_VLV_SAMPLE_CAL], lamp_cmd[5],
        relay_cmd[`RBW_RLY_PERM] && !(stalled || stall_hit), lamp_cmd[3],
        relay_cmd[`RBW_RLY_CONVERTER] && !(stalled || stall_hit),
        relay_cmd[`RBW_RLY_CHAMBER] && !(stalled || stall_hit), beat};
      stall <= stalled || stall_hit;
      irq <= |(int_stat & int_mask);
    end
  end

  always @* begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `RBW_REG_RELAY: next_prdata[`RBW_RELAY_W-1:0] = relay_cmd;
      `RBW_REG_VALVE: next_prdata[7:0] = valve_cmd;
      `RBW_REG_LAMP: next_prdata[12:0] = lamp_cmd;
      `RBW_REG_STATUS: next_prdata[1:0] = {beat, stalled};
      `RBW_REG_INT_STAT: next_prdata[`RBW_EV_W-1:0] = int_stat;
      `RBW_REG_INT_MASK: next_prdata[`RBW_EV_W-1:0] = int_mask;
      `RBW_REG_STALL_CNT: next_prdata = stall_cnt;
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_err;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule // rbw_relay_board
`default_nettype wire

// ---- rbw_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host side: an APB master that flips the heartbeat bit on every relay write.
module rbw_host_model (
  input wire logic core_clk, // Clock.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic [31:0] prdata, // Read data.
  output logic psel, // Select.
  output logic penable, // Enable.
  output logic pwrite, // Direction.
  output logic [11:0] paddr, // Address.
  output logic [31:0] pwdata // Write data.
);
  logic beat = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    if (w && a == 12'h000) beat = !beat;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (w && a == 12'h000) ? {d[31:6], beat, d[4:0]} : d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // rbw_host_model
`default_nettype wire

// ---- rbw_relay_board_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module rbw_relay_board_assertions #(
  parameter [31:0] STALL_CYCLES = 32'h000000C8
) (
  input wire logic core_clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pready, // Ready.
  input wire logic chamber_heater, // Heater.
  input wire logic lamp_source, // Lamp relay.
  input wire logic sample_pump, // Pump.
  input wire logic [7:0] valve_drive, // Valves.
  input wire logic heartbeat_lamp, // Heartbeat.
  input wire logic chamber_heater_lamp, // Heater lamp.
  input wire logic sample_cal_valve_lamp, // Valve lamp.
  input wire logic zero_span_valve_lamp, // Valve lamp.
  input wire logic stall // Shutdown.
);
  logic [31:0] quiet;
  logic beat_q;
  // The margins on quiet absorb the reset synchroniser and output register delays.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 32'h00000000;
      beat_q <= 1'b0;
    end else begin
      quiet <= (heartbeat_lamp != beat_q) ? 32'h00000000 : quiet + 32'h00000001;
      beat_q <= heartbeat_lamp;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  chk_stall_late: assert property (quiet > STALL_CYCLES + 8 |-> stall) else $error("no stall");
  chk_stall_early: assert property ($rose(stall) |-> quiet >= STALL_CYCLES - 2)
    else $error("early stall");
  chk_heaters_off: assert property (stall && $past(stall) |-> !chamber_heater && !lamp_source)
    else $error("heater on in stall");
  chk_valves_off: assert property (stall && $past(stall, 2) |-> valve_drive == 8'h00)
    else $error("valve on in stall");
  chk_pump_kept: assert property ($rose(stall) |-> $stable(sample_pump) [*4])
    else $error("pump moved");
  chk_heater_lamp: assert property ($stable(chamber_heater) |-> chamber_heater_lamp == chamber_heater)
    else $error("heater lamp wrong");
  chk_valve_lamps: assert property ($stable(valve_drive[1:0])
    |-> {zero_span_valve_lamp, sample_cal_valve_lamp} == valve_drive[1:0])
    else $error("valve lamp wrong");
endmodule // rbw_relay_board_assertions
bind rbw_relay_board rbw_relay_board_assertions #(.STALL_CYCLES(STALL_CYCLES)) chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .chamber_heater(chamber_heater), .lamp_source(lamp_source), .sample_pump(sample_pump),
  .valve_drive(valve_drive), .heartbeat_lamp(heartbeat_lamp), .stall(stall),
  .chamber_heater_lamp(chamber_heater_lamp), .sample_cal_valve_lamp(sample_cal_valve_lamp),
  .zero_span_valve_lamp(zero_span_valve_lamp));
`default_nettype wire

// ---- rbw_relay_board_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rbw_defs.vh"
module rbw_relay_board_bench;
  localparam int S = 200;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, stall, irq, ch, cv, pt, ls, pump;
  logic hb, chl, cvl, ptl, scl, zsl, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] vd, p;
  logic [12:0] sl;
  int err_total = 0;
  int n_tests = 0;
  rbw_relay_board #(.STALL_CYCLES(S)) rbw_relay_board_inst (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chamber_heater(ch), .converter_heater(cv), .perm_tube_heater(pt), .lamp_source(ls),
    .sample_pump(pump), .valve_drive(vd), .status_lamps(sl), .heartbeat_lamp(hb),
    .chamber_heater_lamp(chl), .converter_heater_lamp(cvl), .perm_tube_heater_lamp(ptl),
    .sample_cal_valve_lamp(scl), .zero_span_valve_lamp(zsl), .stall(stall), .irq(irq));
  rbw_host_model rbw_host_model_inst (.core_clk(core_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    rbw_host_model_inst.xfer(w, a, d, q, e);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #5 core_clk = ~core_clk;
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'h0A : 8'h15;
      acc(1'b1, `RBW_REG_RELAY, p);
      chk({pump, ls, pt, cv, ch}, p[4:0]);
      chk({ptl, cvl, chl}, p[2:0]);
      p = i ? 8'h5A : 8'hA5;
      acc(1'b1, `RBW_REG_VALVE, p);
      chk(vd, p);
      chk({zsl, scl}, p[1:0]);
    end
    acc(1'b1, `RBW_REG_LAMP, 32'h00001FFF);
    chk(sl & 13'h1A28, 13'h1A28);
    acc(1'b1, `RBW_REG_LAMP, 32'h00000000);
    chk(sl & 13'h1A28, 13'h0000);
    acc(1'b0, 12'h01C, 32'h00000000);
    chk({e, q}, 33'h100000000);
    acc(1'b1, `RBW_REG_INT_MASK, 32'h00000001);
    acc(1'b1, `RBW_REG_RELAY, 32'h0000001F);
    acc(1'b1, `RBW_REG_VALVE, 32'h000000FF);
    repeat (S + 20) @(posedge core_clk);
    chk({stall, irq}, 2'b11);
    chk({pump, ls, pt, cv, ch, ptl, cvl, chl}, 8'h80);
    chk(vd, 8'h00);
    acc(1'b0, `RBW_REG_INT_STAT, 32'h00000000);
    chk(q[0], 1'b1);
    acc(1'b1, `RBW_REG_INT_STAT, 32'h00000001);
    chk(irq, 1'b0);
    acc(1'b1, `RBW_REG_RELAY, 32'h0000001F);
    chk({stall, pump, ls, pt, cv, ch}, 6'h1F);
    repeat (3) begin
      repeat (150) @(posedge core_clk);
      acc(1'b1, `RBW_REG_RELAY, 32'h0000001F);
    end
    chk(stall, 1'b0);
    close_out();
  end
endmodule // rbw_relay_board_bench
`default_nettype wire
